// *** pkg/bsc_pkg.sv ***
// Constants and types for the buck enable and soft-start controller
package bsc_pkg;
    // Clock period in ns
    localparam int CLK_NS = 20;

    // Register byte offsets
    localparam logic [7:0] ADDR_SET0 = 8'h00;
    localparam logic [7:0] ADDR_SET1 = 8'h04;
    localparam logic [7:0] ADDR_CTRL = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0C;

    // Setpoint register fields
    localparam int SET_EN_BIT   = 7;
    localparam int SET_MODE_BIT = 6;
    localparam int CODE_W       = 6;

    // Control register fields
    localparam int CTRL_BLEED_BIT = 7;
    localparam int SLEW_W         = 3;

    // Reset values
    localparam logic [5:0] CODE_RST = 6'h1F;
    localparam logic [7:0] CTRL_RST = 8'h00;

    // Build options, 042 is coded as 142
    localparam int OPT_01  = 1;
    localparam int OPT_03  = 3;
    localparam int OPT_04  = 4;
    localparam int OPT_05  = 5;
    localparam int OPT_24  = 24;
    localparam int OPT_042 = 142;
    localparam int OPT_79  = 79;

    // Current-limit run length
    localparam logic [4:0] ILIM_RUN = 5'h10;

    // Retry wait, then in cycles
    localparam int RETRY_MS  = 1700;
    localparam int RETRY_CYC = RETRY_MS * 1000000 / CLK_NS;

    // Soft-start reference step time
    localparam int SS_STEP_NS  = 1000;
    localparam int SS_STEP_CYC = (SS_STEP_NS + CLK_NS - 1) / CLK_NS;

    // Regulator sequencing states
    typedef enum logic [1:0]
    {
        ST_OFF   = 2'b00,
        ST_SOFT  = 2'b01,
        ST_RUN   = 2'b10,
        ST_RETRY = 2'b11
    } bsc_state_t;
endpackage

// *** rtl/bsc_buck_enable.sv ***
// Enable, soft-start and retry sequencer with AHB-Lite registers
`timescale 1ns/1ps

module bsc_buck_enable
#(
    parameter int BUILD_OPTION = 0,
    parameter int RETRY_CYCLES = bsc_pkg::RETRY_CYC
)
(
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic             hreadyout,
    output logic             hresp,
    output logic [31:0]      hrdata,
    input  wire logic        chip_enable_pin,
    input  wire logic        setpoint_select_pin,
    input  wire logic        cycle_end,
    input  wire logic        cycle_in_ilim,
    output logic             power_stage_en,
    output logic             sync_rect_en,
    output logic [7:0]       soft_ref,
    output logic [5:0]       voltage_code,
    output logic             pwm_only,
    output logic [2:0]       slew_code,
    output logic             bleed_en,
    output logic             core_shutdown
);

    // Default value of a setpoint register
    function automatic logic [7:0] set_default(input logic high);
        logic en;
        en = 1'b1;
        if (BUILD_OPTION == bsc_pkg::OPT_01 || BUILD_OPTION == bsc_pkg::OPT_05)
        begin
            en = ~high;
        end
        return {en, 1'b0, bsc_pkg::CODE_RST};
    endfunction

    localparam logic [7:0] SET0_RST = set_default(1'b0);
    localparam logic [7:0] SET1_RST = set_default(1'b1);
    localparam logic OPT_RESETS = (BUILD_OPTION == bsc_pkg::OPT_04)
                               || (BUILD_OPTION == bsc_pkg::OPT_24)
                               || (BUILD_OPTION == bsc_pkg::OPT_042)
                               || (BUILD_OPTION == bsc_pkg::OPT_79);
    localparam logic [31:0] RETRY_LAST = 32'(RETRY_CYCLES - 1);
    localparam logic [7:0]  SS_LAST = 8'(bsc_pkg::SS_STEP_CYC - 1);

    logic [7:0]        set0_reg;
    logic [7:0]        set1_reg;
    logic [7:0]        ctrl_reg;
    logic              wr_pend_reg;
    logic [7:0]        wr_addr_reg;
    logic [31:0]       hrdata_reg;
    bsc_pkg::bsc_state_t state_reg;
    bsc_pkg::bsc_state_t state_next;
    logic [4:0]        ilim_cnt_reg;
    logic [31:0]       wait_cnt_reg;
    logic [7:0]        ss_div_reg;
    logic [7:0]        ref_reg;

    // Bus decode
    wire        take     = hsel & htrans[1] & hready;
    wire        wr_ok    = wr_pend_reg & chip_enable_pin;
    wire [7:0]  wdat     = hwdata[7:0];
    wire [7:0]  raddr    = haddr[7:0];

    wire sel_eff = (BUILD_OPTION == bsc_pkg::OPT_03) ? 1'b0 : setpoint_select_pin;

    wire [7:0] act_set = sel_eff ? set1_reg : set0_reg;

    wire sw_enable_active = act_set[bsc_pkg::SET_EN_BIT];
    wire want_on = chip_enable_pin & sw_enable_active;

    // Soft-start step divider and limit trip
    wire ss_tick   = (ss_div_reg == SS_LAST);
    wire ref_full  = (ref_reg == 8'hFF);
    wire ilim_trip = cycle_end & cycle_in_ilim
                   & (ilim_cnt_reg == bsc_pkg::ILIM_RUN - 5'h01);
    wire wait_done = (wait_cnt_reg == RETRY_LAST);
    wire running   = (state_reg == bsc_pkg::ST_SOFT)
                   | (state_reg == bsc_pkg::ST_RUN);

    // Status word: regulating, select, state, limit count
    wire [7:0] stat_word = {state_reg == bsc_pkg::ST_RUN, sel_eff,
                            state_reg, 1'b0, ilim_cnt_reg[2:0]};

    // Read data mux
    wire [7:0] rmux = (raddr == bsc_pkg::ADDR_SET0) ? set0_reg  :
                      (raddr == bsc_pkg::ADDR_SET1) ? set1_reg  :
                      (raddr == bsc_pkg::ADDR_CTRL) ? ctrl_reg  :
                      (raddr == bsc_pkg::ADDR_STAT) ? stat_word : 8'h00;

    // Bus response, zero wait
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_reg;

    // Address phase capture
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
            hrdata_reg  <= 32'h0000_0000;
        end
        else
        begin
            wr_pend_reg <= take & hwrite;
            if (take)
            begin
                wr_addr_reg <= raddr;
            end
            if (take && !hwrite)
            begin
                hrdata_reg <= chip_enable_pin ? {24'h000000, rmux} : 32'h0000_0000;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            set0_reg <= SET0_RST;
            set1_reg <= SET1_RST;
            ctrl_reg <= bsc_pkg::CTRL_RST;
        end
        else if (!chip_enable_pin && OPT_RESETS)
        begin
            set0_reg <= SET0_RST;
            set1_reg <= SET1_RST;
            ctrl_reg <= bsc_pkg::CTRL_RST;
        end
        else if (wr_ok)
        begin
            if (wr_addr_reg == bsc_pkg::ADDR_SET0)
            begin
                set0_reg <= wdat;
            end
            if (wr_addr_reg == bsc_pkg::ADDR_SET1)
            begin
                set1_reg <= wdat;
            end
            if (wr_addr_reg == bsc_pkg::ADDR_CTRL)
            begin
                ctrl_reg <= wdat;
            end
        end
    end

    // Sequencer next state
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            bsc_pkg::ST_OFF:
            begin
                if (want_on)
                begin
                    state_next = bsc_pkg::ST_SOFT;
                end
            end
            bsc_pkg::ST_SOFT:
            begin
                if (!want_on)
                begin
                    state_next = bsc_pkg::ST_OFF;
                end
                else if (ilim_trip)
                begin
                    state_next = bsc_pkg::ST_RETRY;
                end
                else if (ref_full)
                begin
                    state_next = bsc_pkg::ST_RUN;
                end
            end
            bsc_pkg::ST_RUN:
            begin
                if (!want_on)
                begin
                    state_next = bsc_pkg::ST_OFF;
                end
                else if (ilim_trip)
                begin
                    state_next = bsc_pkg::ST_RETRY;
                end
            end
            bsc_pkg::ST_RETRY:
            begin
                if (!want_on)
                begin
                    state_next = bsc_pkg::ST_OFF;
                end
                else if (wait_done)
                begin
                    state_next = bsc_pkg::ST_SOFT;
                end
            end
            default:
            begin
                state_next = bsc_pkg::ST_OFF;
            end
        endcase
    end

    // Sequencer state and counters
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            state_reg    <= bsc_pkg::ST_OFF;
            ilim_cnt_reg <= 5'h00;
            wait_cnt_reg <= 32'h0000_0000;
        end
        else
        begin
            state_reg <= state_next;
            if (!running || ilim_trip)
            begin
                ilim_cnt_reg <= 5'h00;
            end
            else if (cycle_end)
            begin
                ilim_cnt_reg <= cycle_in_ilim ? ilim_cnt_reg + 5'h01 : 5'h00;
            end
            wait_cnt_reg <= (state_reg == bsc_pkg::ST_RETRY && !wait_done)
                          ? wait_cnt_reg + 32'h0000_0001 : 32'h0000_0000;
        end
    end

    // Soft-start reference ramp
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            ss_div_reg <= 8'h00;
            ref_reg    <= 8'h00;
        end
        else if (state_reg == bsc_pkg::ST_SOFT)
        begin
            ss_div_reg <= ss_tick ? 8'h00 : ss_div_reg + 8'h01;
            if (ss_tick && !ref_full)
            begin
                ref_reg <= ref_reg + 8'h01;
            end
        end
        else
        begin
            ss_div_reg <= 8'h00;
            ref_reg    <= (state_reg == bsc_pkg::ST_RUN) ? 8'hFF : 8'h00;
        end
    end

    // Regulator controls
    assign power_stage_en = running;
    assign sync_rect_en   = (state_reg == bsc_pkg::ST_RUN);
    assign soft_ref       = ref_reg;
    assign voltage_code   = act_set[bsc_pkg::CODE_W-1:0];
    assign pwm_only       = act_set[bsc_pkg::SET_MODE_BIT];
    assign slew_code      = ctrl_reg[bsc_pkg::SLEW_W-1:0];
    assign bleed_en       = ctrl_reg[bsc_pkg::CTRL_BLEED_BIT]
                          & (~chip_enable_pin | ~sw_enable_active);
    assign core_shutdown  = ~chip_enable_pin;

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    sequence s_turn_on;
        state_reg == bsc_pkg::ST_OFF && want_on;
    endsequence

    sequence s_ramp;
        state_reg == bsc_pkg::ST_SOFT && ref_reg == 8'h00;
    endsequence

    ce_off_a: assert property (!chip_enable_pin |=> state_reg == bsc_pkg::ST_OFF)
        else $error("regulator not off while disabled");

    regs_kept_a: assert property (!OPT_RESETS && !chip_enable_pin |=>
        $stable(set0_reg) && $stable(set1_reg) && $stable(ctrl_reg))
        else $error("registers changed while disabled");

    regs_clear_a: assert property (OPT_RESETS && !chip_enable_pin |=>
        set0_reg == SET0_RST && set1_reg == SET1_RST)
        else $error("registers not defaulted while disabled");

    // No bleed load while switched on
    bleed_off_a: assert property (want_on |-> !bleed_en)
        else $error("bleed load on while enabled");

    start_ramp_a: assert property (s_turn_on |=> s_ramp)
        else $error("soft-start not begun on turn-on");

    ramp_rect_a: assert property (state_reg == bsc_pkg::ST_SOFT |-> !sync_rect_en)
        else $error("rectifier on during soft-start");

    trip_off_a: assert property (running && ilim_trip && want_on |=>
        !power_stage_en ##1 !power_stage_en)
        else $error("output not tristated after limit run");

    run_enable_a: assert property (state_reg == bsc_pkg::ST_RUN |->
        $past(want_on))
        else $error("running without active enable");

    sel_tie_a: assert property (BUILD_OPTION == bsc_pkg::OPT_03 |->
        voltage_code == set0_reg[bsc_pkg::CODE_W-1:0])
        else $error("select not tied low");

    run_clear_a: assert property (cycle_end && !cycle_in_ilim |=>
        ilim_cnt_reg == 5'h00)
        else $error("limit count not cleared");

endmodule

// *** bench/bsc_host_model.sv ***
// Far-side model: switching-cycle pulses with a current-limit flag
`timescale 1ns/1ps

module bsc_host_model
(
    input  wire logic hclk,
    input  wire logic hresetn,
    input  wire logic lim_req,
    output logic      cycle_end,
    output logic      cycle_in_ilim
);
    logic [1:0] phase_reg;

    // One cycle end every four clocks, flag inverted between pulses
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            phase_reg     <= 2'h0;
            cycle_end     <= 1'b0;
            cycle_in_ilim <= 1'b0;
        end
        else
        begin
            phase_reg     <= phase_reg + 2'h1;
            cycle_end     <= (phase_reg == 2'h3);
            cycle_in_ilim <= (phase_reg == 2'h3) ? lim_req : ~lim_req;
        end
    end
endmodule

// *** bench/tb.sv ***
// Testbench: AHB-Lite register access, enable and retry sequencing
`timescale 1ns/1ps

module tb;
    logic        hclk    = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel    = 1'b0;
    logic [31:0] haddr   = 32'h0;
    logic [1:0]  htrans  = 2'b00;
    logic        hwrite  = 1'b0;
    logic [2:0]  hsize   = 3'b010;
    logic [31:0] hwdata  = 32'h0;
    logic        ce      = 1'b1;
    logic        sel     = 1'b0;
    logic        lim     = 1'b0;
    logic        hreadyout, hresp, cyc_end, cyc_lim;
    logic        pse, sre, pwm, bleed, shut;
    logic        pse_b, pwm_b;
    logic [5:0]  vcode_b, vcode_c;
    logic [31:0] hrdata;
    logic [7:0]  sref;
    logic [5:0]  vcode;
    logic [2:0]  slew;
    logic [31:0] q;
    int          failures = 0;
    int          checks   = 0;

    // Clock, 20 ns period
    always #10 hclk = ~hclk;

    bsc_buck_enable #(.BUILD_OPTION(1), .RETRY_CYCLES(20)) u_dut
    (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .chip_enable_pin(ce), .setpoint_select_pin(sel),
        .cycle_end(cyc_end), .cycle_in_ilim(cyc_lim), .power_stage_en(pse),
        .sync_rect_en(sre), .soft_ref(sref), .voltage_code(vcode),
        .pwm_only(pwm), .slew_code(slew), .bleed_en(bleed),
        .core_shutdown(shut)
    );

    bsc_host_model u_host
    (
        .hclk(hclk), .hresetn(hresetn), .lim_req(lim),
        .cycle_end(cyc_end), .cycle_in_ilim(cyc_lim)
    );

    // Option that clears registers while disabled, both enables set
    bsc_buck_enable #(.BUILD_OPTION(bsc_pkg::OPT_04), .RETRY_CYCLES(20)) u_dut_b
    (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(), .hresp(), .hrdata(),
        .chip_enable_pin(ce), .setpoint_select_pin(sel),
        .cycle_end(cyc_end), .cycle_in_ilim(cyc_lim), .power_stage_en(pse_b),
        .sync_rect_en(), .soft_ref(), .voltage_code(vcode_b),
        .pwm_only(pwm_b), .slew_code(), .bleed_en(), .core_shutdown()
    );

    // Option with the select input tied low inside
    bsc_buck_enable #(.BUILD_OPTION(bsc_pkg::OPT_03), .RETRY_CYCLES(20)) u_dut_c
    (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hreadyout(), .hresp(), .hrdata(),
        .chip_enable_pin(ce), .setpoint_select_pin(sel),
        .cycle_end(cyc_end), .cycle_in_ilim(cyc_lim), .power_stage_en(),
        .sync_rect_en(), .soft_ref(), .voltage_code(vcode_c),
        .pwm_only(), .slew_code(), .bleed_en(), .core_shutdown()
    );

    // Verdict and end of run
    task automatic stop_test();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // Compare one value
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Bounded wait for hready at a rising edge
    task automatic wait_rdy();
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1)
        begin
            n++;
            if (n > 50)
            begin
                failures++;
                $display("wrong value at %0t: bus ready never came", $time);
                stop_test();
            end
            @(posedge hclk);
        end
    endtask

    // One AHB-Lite single word transfer
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge hclk);
        hsel   <= 1'b1;
        htrans <= 2'b10;
        haddr  <= {24'h0, a};
        hwrite <= w;
        wait_rdy();
        htrans <= 2'b00;
        hwdata <= d;
        wait_rdy();
        q = hrdata;
        #1;
    endtask

    // Count switching-cycle pulses, bounded
    task automatic pulses(input int n);
        int k;
        k = 0;
        for (int i = 0; i < n * 8 && k < n; i++)
        begin
            @(posedge hclk);
            if (cyc_end === 1'b1)
                k++;
        end
        if (k < n)
        begin
            failures++;
            $display("wrong value at %0t: cycle pulses missing", $time);
            stop_test();
        end
        #1;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge hclk);
        #1;
    endtask

    // Main sequence
    initial
    begin
        int n;
        tick(3);
        hresetn = 1'b1;
        bus(1'b0, bsc_pkg::ADDR_SET0, 32'h0); chk(q, 32'h9F);
        bus(1'b0, bsc_pkg::ADDR_SET1, 32'h0); chk(q, 32'h1F);
        bus(1'b0, bsc_pkg::ADDR_CTRL, 32'h0); chk(q, 32'h00);
        chk(vcode, 32'h1F);
        chk(pse, 32'h1);
        tick(50);
        chk(sref, 32'h01);
        chk(sre, 32'h0);
        n = 0;
        while (sre !== 1'b1 && n < 14000)
        begin
            tick(1);
            n++;
        end
        if (sre !== 1'b1)
        begin
            failures++;
            $display("wrong value at %0t: soft-start never ended", $time);
            stop_test();
        end
        chk(sref, 32'hFF);
        sel <= 1'b1;
        tick(3);
        chk(pse, 32'h0);
        chk(pse_b, 32'h1);
        bus(1'b1, bsc_pkg::ADDR_SET1, 32'hC5);
        tick(1);
        chk({sref, pwm, vcode}, {8'h00, 1'b1, 6'h05});
        chk(vcode_c, 32'h1F);
        chk(pse, 32'h1);
        lim <= 1'b1;
        pulses(15);
        lim <= 1'b0;
        pulses(1);
        lim <= 1'b1;
        pulses(15);
        tick(2);
        chk(pse, 32'h1);
        pulses(1);
        lim <= 1'b0;
        tick(3);
        chk(pse, 32'h0);
        tick(10);
        chk(pse, 32'h0);
        tick(20);
        chk(pse, 32'h1);
        bus(1'b1, bsc_pkg::ADDR_CTRL, 32'h87);
        tick(1);
        chk({slew, bleed}, {3'h7, 1'b0});
        bus(1'b1, bsc_pkg::ADDR_SET1, 32'h45);
        tick(1);
        chk({pse, bleed}, 32'h1);
        ce <= 1'b0;
        tick(2);
        chk(shut, 32'h1);
        chk({pwm_b, vcode_b}, {1'b0, 6'h1F});
        chk({pwm, vcode}, {1'b1, 6'h05});
        bus(1'b0, bsc_pkg::ADDR_SET1, 32'h0); chk(q, 32'h0);
        chk(hresp, 32'h0);
        bus(1'b1, bsc_pkg::ADDR_SET0, 32'h00);
        ce  <= 1'b1;
        sel <= 1'b0;
        bus(1'b0, bsc_pkg::ADDR_SET1, 32'h0); chk(q, 32'h45);
        bus(1'b0, bsc_pkg::ADDR_SET0, 32'h0); chk(q, 32'h9F);
        bus(1'b0, bsc_pkg::ADDR_STAT, 32'h0); chk(q, 32'h10);
        tick(2);
        chk({pse, bleed, shut}, 32'h4);
        stop_test();
    end
endmodule
